// ==== amc_pkg.sv ====
// constants and types shared by the converter mode register bank
// assumes one 250 MHz clock and a classic wishbone register port
package amc_pkg;

  ////////////////////////////////////////////////////////////////////
  // timing
  localparam int MCLK_PERIOD_NS = 4;
  localparam int US_NS = 1000;
  localparam int US_CYCLES_DEF = US_NS / MCLK_PERIOD_NS;
  localparam int PRESC_W = 12;
  localparam int US_W = 15;

  ////////////////////////////////////////////////////////////////////
  // register indices, byte addresses are four times the index
  localparam logic [7:0] RF_IDX = 8'h02;
  localparam logic [7:0] CC_IDX = 8'h03;
  localparam logic [7:0] PS_IDX = 8'h04;
  localparam logic [7:0] PL_IDX = 8'h05;
  localparam logic [7:0] RF_ADDR = {RF_IDX[5:0], 2'h0};
  localparam logic [7:0] CC_ADDR = {CC_IDX[5:0], 2'h0};
  localparam logic [7:0] PS_ADDR = {PS_IDX[5:0], 2'h0};
  localparam logic [7:0] PL_ADDR = {PL_IDX[5:0], 2'h0};

  // reset values
  localparam logic [7:0] RF_RESET = 8'h24;
  localparam logic [7:0] CC_RESET = 8'h01;
  localparam logic [7:0] PS_RESET = 8'h00;
  localparam logic [3:0] PL_RESET = 4'h0;

  // field positions
  localparam int RATE_LSB = 3;
  localparam int FILT_LSB = 0;
  localparam int CHOP_BIT = 5;
  localparam int ONESHOT_BIT = 4;
  localparam int DELAY_LSB = 0;
  localparam int ATTACH_LSB = 4;
  localparam int DIR_LSB = 0;
  localparam int REFPOS_PIN = 0;
  localparam int REFNEG_PIN = 1;

  // every code at or above this selects the top rate
  localparam logic [4:0] RATE_TOP = 5'h10;

  typedef enum logic [2:0] {
    FILT_SINC1 = 3'h0,
    FILT_SINC2 = 3'h1,
    FILT_SINC3 = 3'h2,
    FILT_SINC4 = 3'h3,
    FILT_FIR = 3'h4
  } amc_filter_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_DELAY = 2'h1,
    ST_FIRE = 2'h3
  } amc_state_t;

  typedef struct packed {
    logic [7:0] rateFilter;
    logic [7:0] convCtrl;
    logic [7:0] pinSetup;
    logic [3:0] pinData;
    logic ack;
    logic [7:0] rdData;
    amc_state_t state;
    logic [PRESC_W-1:0] presc;
    logic [US_W-1:0] usLeft;
    logic [4:0] rateSel;
    logic [2:0] filterSel;
    logic chopEnable;
    logic oneShot;
    logic convGo;
    logic convBusy;
    logic [3:0] padOut;
    logic [3:0] padOeB;
    logic refPosFree;
    logic refNegFree;
  } amc_regs_t;

  // saturate the rate code onto the top rate
  function automatic logic [4:0] rate_index(input logic [4:0] code);
    return code[4] ? RATE_TOP : code;
  endfunction

  // start delay in microseconds; reserved codes take the longest
  function automatic logic [US_W-1:0] delay_us(input logic [3:0] code);
    case (code)
      4'h0: return 15'h0000;
      4'h1: return 15'(50);
      4'h2: return 15'(59);
      4'h3: return 15'(67);
      4'h4: return 15'(85);
      4'h5: return 15'(119);
      4'h6: return 15'(189);
      4'h7: return 15'(328);
      4'h8: return 15'(605);
      4'h9: return 15'(1160);
      4'hA: return 15'(2270);
      4'hB: return 15'(4490);
      4'hC: return 15'(8930);
      default: return 15'(17800);
    endcase
  endfunction

endpackage

// ==== amc_pad_sync.sv ====
// two-stage synchroniser for the general-purpose pad inputs
// assumes pads change with no relation to mclk
module amc_pad_sync #(
  parameter int W = 4
) (
  input wire logic mclk, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic ce, // clock enable
  input wire logic [W-1:0] padIn, // raw pad levels
  output logic [W-1:0] pinLevel // synchronised pad levels
);
  import amc_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } amc_sync_t;

  amc_sync_t s;
  amc_sync_t next_s;

  always_comb begin
    next_s = s;
    next_s.meta = padIn;
    next_s.stable = s.meta;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign pinLevel = s.stable;

endmodule

// ==== amc_mode_regs.sv ====
// rate/filter, conversion control and pin setup registers of the
// converter, with the conversion start delay timer and pad control
// assumes a classic wishbone master on mclk and a conversion request
// strobe from logic on the same clock
//
// Overview of operation
// - rate field picks ascending rates, default 4
// - codes 10000 and up give top rate
// - filter field picks sinc1..sinc4 or fir
// - rate/filter register at 02h, resets 24h
// - bit 5 enables auto-zero operation
// - bit 4 selects one-shot over continuous
// - delay code sets wait before conversion
// - conversion control at 03h, resets 01h
// - upper pin setup bits attach pin functions
// - lower pin setup bits set pin direction
// - pins 0 and 1 share reference pads
// - pin setup at 04h, resets 00h
// - pin data reads pad, drives outputs
//
// The implementer's own choice: the Wishbone slave port.
module amc_mode_regs #(
  parameter logic [11:0] US_CYCLES = 12'(amc_pkg::US_CYCLES_DEF)
) (
  input wire logic mclk, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic cyc_i, // wishbone cycle
  input wire logic stb_i, // wishbone strobe
  input wire logic we_i, // wishbone write enable
  input wire logic [7:0] adr_i, // wishbone byte address
  input wire logic [3:0] sel_i, // wishbone byte selects
  input wire logic [31:0] dat_i, // wishbone write data
  output logic [31:0] dat_o, // wishbone read data
  output logic ack_o, // wishbone acknowledge
  input wire logic convReq, // conversion setup request, one cycle
  output logic [4:0] rateSel, // active rate index, 16 is top rate
  output logic [2:0] filterSel, // active filter code
  output logic chopEnable, // active auto-zero enable
  output logic oneShot, // active one-shot mode
  output logic convGo, // conversion start, one cycle
  output logic convBusy, // setup accepted, start pending
  input wire logic [3:0] padIn, // pad input levels
  output logic [3:0] padOut, // pad drive levels
  output logic [3:0] padOe_b, // pad drive enable, active low
  output logic refPosFree, // positive reference pad left to analog
  output logic refNegFree // negative reference pad left to analog
);
  import amc_pkg::*;

  localparam logic [PRESC_W-1:0] PRESC_LAST = US_CYCLES - 12'h001;

  amc_regs_t q;
  amc_regs_t next_q;
  logic [3:0] pinLevel;
  logic access;
  logic [US_W-1:0] dly;

  ////////////////////////////////////////////////////////////////////
  // pad input synchroniser

  amc_pad_sync #(
    .W(4)
  ) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .ce(ce),
    .padIn(padIn),
    .pinLevel(pinLevel)
  );

  ////////////////////////////////////////////////////////////////////
  // register read mux, unmapped addresses read zero

  function automatic logic [7:0] read_reg(
    input logic [7:0] adr,
    input amc_regs_t r,
    input logic [3:0] pins
  );
    if (adr == RF_ADDR) begin
      return r.rateFilter;
    end else if (adr == CC_ADDR) begin
      return r.convCtrl;
    end else if (adr == PS_ADDR) begin
      return r.pinSetup;
    end else if (adr == PL_ADDR) begin
      return {4'h0, pins};
    end else begin
      return 8'h00;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_q = q;
    dly = delay_us(q.convCtrl[DELAY_LSB +: 4]);
    access = cyc_i && stb_i;
    next_q.convGo = 1'b0;

    // bus: ack one cycle after the request, dropped the next
    next_q.ack = access && !q.ack;
    if (access && !q.ack) begin
      next_q.rdData = read_reg(adr_i, q, pinLevel);
    end

    // writes land on the edge that completes the cycle
    if (access && q.ack && we_i && sel_i[0]) begin
      if (adr_i == RF_ADDR) begin
        next_q.rateFilter = dat_i[7:0];
      end else if (adr_i == CC_ADDR) begin
        next_q.convCtrl = dat_i[7:0];
      end else if (adr_i == PS_ADDR) begin
        next_q.pinSetup = dat_i[7:0];
      end else if (adr_i == PL_ADDR) begin
        next_q.pinData = dat_i[3:0];
      end
    end

    // pad control follows the pin registers directly
    next_q.padOut = next_q.pinData;
    next_q.padOeB = ~(next_q.pinSetup[ATTACH_LSB +: 4] &
                      ~next_q.pinSetup[DIR_LSB +: 4]);
    next_q.refPosFree =
      !next_q.pinSetup[ATTACH_LSB + REFPOS_PIN];
    next_q.refNegFree =
      !next_q.pinSetup[ATTACH_LSB + REFNEG_PIN];

    // conversion setup and start delay
    case (q.state)
      ST_IDLE: begin
        if (convReq) begin
          // shadow settings become active only here
          next_q.rateSel =
            rate_index(q.rateFilter[RATE_LSB +: 5]);
          next_q.filterSel = q.rateFilter[FILT_LSB +: 3];
          next_q.chopEnable = q.convCtrl[CHOP_BIT];
          next_q.oneShot = q.convCtrl[ONESHOT_BIT];
          next_q.convBusy = 1'b1;
          next_q.presc = '0;
          next_q.usLeft = dly;
          if (dly == '0) begin
            next_q.state = ST_FIRE;
            next_q.convGo = 1'b1;
          end else begin
            next_q.state = ST_DELAY;
          end
        end
      end
      ST_DELAY: begin
        if (q.presc == PRESC_LAST) begin
          next_q.presc = '0;
          if (q.usLeft == 15'h0001) begin
            next_q.state = ST_FIRE;
            next_q.convGo = 1'b1;
          end else begin
            next_q.usLeft = q.usLeft - 15'h0001;
          end
        end else begin
          next_q.presc = q.presc + 12'h001;
        end
      end
      ST_FIRE: begin
        next_q.state = ST_IDLE;
        next_q.convBusy = 1'b0;
      end
      default: begin
        next_q.state = ST_IDLE;
        next_q.convBusy = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      q <= '0;
      q.rateFilter <= RF_RESET;
      q.convCtrl <= CC_RESET;
      q.pinSetup <= PS_RESET;
      q.pinData <= PL_RESET;
      q.state <= ST_IDLE;
      q.rateSel <= rate_index(RF_RESET[RATE_LSB +: 5]);
      q.filterSel <= RF_RESET[FILT_LSB +: 3];
      q.chopEnable <= CC_RESET[CHOP_BIT];
      q.oneShot <= CC_RESET[ONESHOT_BIT];
      q.padOut <= PL_RESET;
      q.padOeB <= 4'hF;
      q.refPosFree <= 1'b1;
      q.refNegFree <= 1'b1;
    end else if (ce) begin
      q <= next_q;
    end
  end

  assign dat_o = {24'h000000, q.rdData};
  assign ack_o = q.ack;
  assign rateSel = q.rateSel;
  assign filterSel = q.filterSel;
  assign chopEnable = q.chopEnable;
  assign oneShot = q.oneShot;
  assign convGo = q.convGo;
  assign convBusy = q.convBusy;
  assign padOut = q.padOut;
  assign padOe_b = q.padOeB;
  assign refPosFree = q.refPosFree;
  assign refNegFree = q.refNegFree;

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  rate_reset_a: assert property (
    !$past(rst_b) |-> q.rateFilter == RF_RESET && rateSel == 5'h04
  ) else $error("rate/filter register not at reset value");

  ctrl_reset_a: assert property (
    !$past(rst_b) |-> q.convCtrl == CC_RESET && !oneShot
  ) else $error("conversion control not at reset value");

  pin_reset_a: assert property (
    !$past(rst_b) |-> q.pinSetup == PS_RESET && padOe_b == 4'hF
  ) else $error("pin setup not at reset value");

  rate_latch_a: assert property (
    ce && convReq && q.state == ST_IDLE && !q.rateFilter[7]
    |=> rateSel == $past(q.rateFilter[7:3])
  ) else $error("rate index not taken from register");

  rate_top_a: assert property (
    ce && convReq && q.state == ST_IDLE && q.rateFilter[7]
    |=> rateSel == 5'h10
  ) else $error("high rate codes do not select top rate");

  filter_latch_a: assert property (
    ce && convReq && q.state == ST_IDLE
    |=> filterSel == $past(q.rateFilter[2:0])
  ) else $error("filter code not taken from register");

  chop_latch_a: assert property (
    ce && convReq && q.state == ST_IDLE
    |=> chopEnable == $past(q.convCtrl[5])
  ) else $error("auto-zero enable not taken from register");

  shot_latch_a: assert property (
    ce && convReq && q.state == ST_IDLE
    |=> oneShot == $past(q.convCtrl[4])
  ) else $error("conversion mode not taken from register");

  zero_delay_a: assert property (
    ce && convReq && q.state == ST_IDLE && q.convCtrl[3:0] == 4'h0
    |=> convGo ##1 !convGo
  ) else $error("zero delay start not immediate");

  delay_quiet_a: assert property (
    ce && convReq && q.state == ST_IDLE && q.convCtrl[3:0] != 4'h0
    |=> !convGo && convBusy && q.usLeft == $past(dly)
  ) else $error("delay not loaded or start too early");

  pin_drive_a: assert property (
    padOe_b == ~(q.pinSetup[7:4] & ~q.pinSetup[3:0])
  ) else $error("pad drive does not follow pin setup");

  pin_input_a: assert property (
    (~padOe_b & q.pinSetup[3:0]) == 4'h0
  ) else $error("input pin is driven");

  ref_share_a: assert property (
    refPosFree == !q.pinSetup[4] && refNegFree == !q.pinSetup[5]
  ) else $error("shared reference pad state wrong");

  pin_read_a: assert property (
    ce && cyc_i && stb_i && !ack_o && !we_i && adr_i == PL_ADDR
    |=> ack_o && dat_o == {28'h0000000, $past(pinLevel)}
  ) else $error("pin level read wrong");

  ctrl_read_a: assert property (
    ce && cyc_i && stb_i && !ack_o && !we_i && adr_i == CC_ADDR
    |=> ack_o && dat_o[7:0] == $past(q.convCtrl)
  ) else $error("conversion control read back wrong");

  write_hold_a: assert property (
    ce && cyc_i && stb_i && ack_o && we_i && sel_i[0] &&
    adr_i == RF_ADDR |=> q.rateFilter == $past(dat_i[7:0])
  ) else $error("rate/filter write not stored");

endmodule

// ==== amc_mode_regs_tb.sv ====
// self-checking bench for the converter mode register bank
// assumes amc_pkg, amc_pad_sync and amc_mode_regs are compiled first, no other model
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import amc_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // shortened microsecond count keeps the longest delays affordable
  localparam logic [11:0] US = 12'h002;
  localparam int LIMIT = 85000;
  int dly [16] = '{0, 50, 59, 67, 85, 119, 189, 328, 605, 1160, 2270,
    4490, 8930, 17800, 17800, 17800};

  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic cycI = 1'b0;
  logic stbI = 1'b0;
  logic weI = 1'b0;
  logic [7:0] adrI = 8'h00;
  logic [3:0] selI = 4'h0;
  logic [31:0] datI = 32'h0000_0000;
  logic [31:0] datO;
  logic ackO;
  logic convReq = 1'b0;
  logic [4:0] rateSel;
  logic [2:0] filterSel;
  logic chopEnable;
  logic oneShot;
  logic convGo;
  logic convBusy;
  logic [3:0] padIn = 4'h0;
  logic [3:0] padOut;
  logic [3:0] padOe_b;
  logic refPosFree;
  logic refNegFree;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] q;
  logic [7:0] v;
  logic [7:0] pins [4] = '{8'hF0, 8'hF5, 8'h3A, 8'h00};

  always #2 mclk = ~mclk;

  amc_mode_regs #(.US_CYCLES(US)) DUT (
    .mclk(mclk), .rst_b(rst_b), .ce(ce), .cyc_i(cycI), .stb_i(stbI),
    .we_i(weI), .adr_i(adrI), .sel_i(selI), .dat_i(datI), .dat_o(datO),
    .ack_o(ackO), .convReq(convReq), .rateSel(rateSel),
    .filterSel(filterSel), .chopEnable(chopEnable), .oneShot(oneShot),
    .convGo(convGo), .convBusy(convBusy), .padIn(padIn),
    .padOut(padOut), .padOe_b(padOe_b), .refPosFree(refPosFree),
    .refNegFree(refNegFree)
  );

  ////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] exp,
    input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic summarize();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      $display("Error timeout expected below %0d seen %0d", LIMIT, cycles);
      summarize();
    end
  end

  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a,
    input logic [7:0] d, input logic s, output logic [7:0] r);
    @(posedge mclk);
    cycI <= 1'b1;
    stbI <= 1'b1;
    weI <= we;
    adrI <= a;
    selI <= {3'h7, s};
    datI <= {24'h00_0000, d};
    do @(posedge mclk); while (ackO !== 1'b1);
    r = datO[7:0];
    if (!we) check("read upper bits", 32'h0, {8'h00, datO[31:8]});
    cycI <= 1'b0;
    stbI <= 1'b0;
    #1;
    check("ack width", 32'h0, {31'h0, ackO});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    wb(1'b1, a, d, 1'b1, r);
  endtask

  // request a setup, check settings next cycle and the start moment
  task automatic conv(input int expCyc, input logic [4:0] eRate,
    input logic [2:0] eFilt, input logic eChop, input logic eOne);
    int k;
    logic hit;
    @(posedge mclk);
    convReq <= 1'b1;
    @(posedge mclk);
    convReq <= 1'b0;
    k = 0;
    hit = 1'b0;
    while (!hit && k < expCyc + 2) begin
      #1;
      k++;
      if (k == 1) begin
        check("rateSel", {27'h0, eRate}, {27'h0, rateSel});
        check("filterSel", {29'h0, eFilt}, {29'h0, filterSel});
        check("chopEnable", {31'h0, eChop}, {31'h0, chopEnable});
        check("oneShot", {31'h0, eOne}, {31'h0, oneShot});
        check("convBusy", 32'h1, {31'h0, convBusy});
      end
      hit = (convGo === 1'b1);
      @(posedge mclk);
      // a second request while busy must leave the timing alone
      if (k == 4 && expCyc > 8) convReq <= 1'b1;
      if (k == 5 && expCyc > 8) convReq <= 1'b0;
    end
    check("start delay", expCyc, k);
    #1;
    check("convGo width", 32'h0, {31'h0, convGo});
    check("convBusy end", 32'h0, {31'h0, convBusy});
  endtask

  // reset levels of rateSel, convBusy, padOe_b, the reference flags and the three setup registers
  task automatic reset_values();
    logic [7:0] r;
    check("reset rateSel", 32'h4, {27'h0, rateSel});
    check("reset convBusy", 32'h0, {31'h0, convBusy});
    check("reset padOe_b", 32'hF, {28'h0, padOe_b});
    check("reset refFree", 32'h3, {30'h0, refNegFree, refPosFree});
    wb(1'b0, RF_ADDR, 8'h00, 1'b1, r);
    check("rate_filter_config reset", 32'h24, {24'h0, r});
    wb(1'b0, CC_ADDR, 8'h00, 1'b1, r);
    check("conversion_control reset", 32'h01, {24'h0, r});
    wb(1'b0, PS_ADDR, 8'h00, 1'b1, r);
    check("pin_setup reset", 32'h00, {24'h0, r});
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    reset_values();
    wr(8'h40, 8'h5A);
    wb(1'b0, 8'h40, 8'h00, 1'b1, q);
    check("unmapped read", 32'h0, {24'h0, q});
    wb(1'b1, RF_ADDR, 8'h11, 1'b0, q);
    wb(1'b0, RF_ADDR, 8'h00, 1'b1, q);
    check("masked write", 32'h24, {24'h0, q});
    wr(CC_ADDR, 8'h3D);
    wb(1'b0, CC_ADDR, 8'h00, 1'b1, q);
    check("conversion_control back", 32'h3D, {24'h0, q});
    wr(CC_ADDR, 8'h00);
    wr(RF_ADDR, 8'h00);
    #1;
    check("setting before setup", 32'h4, {27'h0, rateSel});
    for (int i = 0; i < 32; i++) begin
      v = {i[4:0], 3'(i % 5)};
      // zero delay kept off the two fastest rates
      if (i == 15) wr(CC_ADDR, 8'h01);
      wr(RF_ADDR, v);
      wb(1'b0, RF_ADDR, 8'h00, 1'b1, q);
      check("rate_filter_config back", v, {24'h0, q});
      conv((i >= 15) ? 1 + dly[1] * int'(US) : 1,
        (i >= 16) ? 5'h10 : i[4:0], v[2:0], 1'b0, 1'b0);
    end
    // top rate here; zero delay and reserved codes 14 and 15 stay unused, reserved code 13 is run
    for (int i = 1; i < 14; i++) begin
      wr(CC_ADDR, {2'h0, i[0], i[1], i[3:0]});
      conv(1 + dly[i] * int'(US), 5'h10, 3'h1, i[0], i[1]);
    end
    wr(PL_ADDR, 8'h0A);
    #1;
    check("padOut", 32'hA, {28'h0, padOut});
    @(posedge mclk);
    padIn <= 4'h6;
    repeat (3) @(posedge mclk);
    wb(1'b0, PL_ADDR, 8'h00, 1'b1, q);
    check("pin level", 32'h6, {28'h0, q[3:0]});
    for (int i = 0; i < 4; i++) begin
      v = pins[i];
      wr(PS_ADDR, v);
      #1;
      check("padOe_b", {28'h0, ~(v[7:4] & ~v[3:0])},
        {28'h0, padOe_b});
      check("refPosFree", {31'h0, ~v[4]}, {31'h0, refPosFree});
      check("refNegFree", {31'h0, ~v[5]}, {31'h0, refNegFree});
      wb(1'b0, PS_ADDR, 8'h00, 1'b1, q);
      check("pin_setup back", v, {24'h0, q});
    end
    // a setup request while the clock enable is low is lost
    @(posedge mclk);
    ce <= 1'b0;
    convReq <= 1'b1;
    @(posedge mclk);
    convReq <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    check("frozen convBusy", 32'h0, {31'h0, convBusy});
    // second reset in mid-run
    @(posedge mclk);
    ce <= 1'b1;
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    reset_values();
    summarize();
  end
endmodule
